// File: rtl/gcr_pkg.sv
// register map, field positions, timing counts and carrier types
package gcr_pkg;

  // =====================================================
  // bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // =====================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_DEBUG = 8'h92;
  localparam logic [ADDR_W-1:0] OFS_LOCK = 8'h93;
  localparam logic [ADDR_W-1:0] OFS_CLR = 8'h94;
  localparam logic [ADDR_W-1:0] OFS_SPARE = 8'h95;
  localparam logic [ADDR_W-1:0] OFS_CKEY = 8'h96;
  localparam logic [ADDR_W-1:0] OFS_NVMCTL = 8'h97;
  localparam logic [ADDR_W-1:0] OFS_NKEY = 8'h98;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h99;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h9a;
  localparam logic [ADDR_W-1:0] OFS_NVM_STAT = 8'h9b;

  // =====================================================
  // field positions
  localparam int DBG_FS_BIT = 1;
  localparam int DBG_ERR_BIT = 0;
  localparam int CLR_REINIT_BIT = 2;
  localparam int CLR_RELOAD_BIT = 1;
  localparam int CLR_DEFAULT_BIT = 0;
  localparam int NVM_MODE_BIT = 0;
  localparam int NVM_GO_BIT = 1;
  localparam int NST_DONE_BIT = 0;
  localparam int LOCK_W = 3;
  localparam int EV_W = 3;
  localparam int EV_DONE = 0;
  localparam int EV_ERR = 1;
  localparam int EV_FS = 2;

  // =====================================================
  // reset values and key sequences
  localparam logic [LOCK_W-1:0] LOCK_RESET = 3'h3;
  localparam int CKEY_LEN = 4;
  localparam logic [CKEY_LEN*8-1:0] CKEY_SEQ = 32'h434f4445;
  localparam int NKEY_LEN = 6;
  localparam logic [NKEY_LEN*8-1:0] NKEY_SEQ = 48'h000402090209;

  // =====================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int ERR_PULSE_US = 50;
  localparam int ERR_PULSE_CYCLES = ERR_PULSE_US * CLK_MHZ;

  // =====================================================
  // carrier types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gcr_bus_req_t;

  typedef struct packed {
    logic brightness;
    logic cfg;
    logic current;
  } gcr_protect_t;

endpackage

// File: rtl/gcr_key_gate.sv
// keyed unlock sequencer: grants access after the full byte sequence
`timescale 1ns/1ns
module gcr_key_gate #(
  parameter int KEY_LEN = 4,
  parameter logic [KEY_LEN*8-1:0] KEY_SEQ = '0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic keyWr,
  input wire logic [7:0] keyByte,
  output logic granted,
  output logic [7:0] lastByte
);
  localparam int IDX_W = $clog2(KEY_LEN);

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic granted;
    logic [7:0] last;
  } gcr_key_state_t;

  gcr_key_state_t st_q;
  gcr_key_state_t st_d;
  logic [7:0] expected;
  logic [7:0] firstKey;

  if (KEY_LEN < 2) begin : g_chk
    $error("key sequence needs at least two bytes");
  end

  // expected byte at the current position
  assign expected = KEY_SEQ[8*(KEY_LEN-1-int'(st_q.idx)) +: 8];
  assign firstKey = KEY_SEQ[8*(KEY_LEN-1) +: 8];

  // sequence walk
  always_comb
  begin
    st_d = st_q;
    if (clear)
    begin
      st_d = '0;
    end
    else if (keyWr)
    begin
      st_d.last = keyByte;
      if (keyByte == expected)
      begin
        if (int'(st_q.idx) == KEY_LEN - 1)
        begin
          st_d.granted = 1'b1;
          st_d.idx = '0;
        end
        else
        begin
          st_d.idx = st_q.idx + 1'b1;
        end
      end
      else
      begin
        st_d.granted = 1'b0;
        st_d.idx = (keyByte == firstKey) ? IDX_W'(1) : '0;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign granted = st_q.granted;
  assign lastByte = st_q.last;

  a_key_restart_lock: assert property (
    @(posedge sys_clk) disable iff (reset)
    keyWr && !clear && keyByte != expected |=> !granted)
    else $error("mismatched key byte left access granted");

endmodule

// File: rtl/gcr_pulse_timer.sv
// one-shot pulse stretcher of a fixed cycle count
`timescale 1ns/1ns
module gcr_pulse_timer #(
  parameter int CYCLES = 5000
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic start,
  output logic active
);
  localparam int CNT_W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic active;
  } gcr_tmr_state_t;

  gcr_tmr_state_t st_q;
  gcr_tmr_state_t st_d;

  if (CYCLES < 1) begin : g_chk
    $error("pulse length must be at least one cycle");
  end

  // load on start, count down while active
  always_comb
  begin
    st_d = st_q;
    if (clear)
    begin
      st_d = '0;
    end
    else if (start)
    begin
      st_d.cnt = CNT_W'(CYCLES - 1);
      st_d.active = 1'b1;
    end
    else if (st_q.active)
    begin
      if (st_q.cnt == '0)
        st_d.active = 1'b0;
      else
        st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign active = st_q.active;

  a_pulse_end_count: assert property (
    @(posedge sys_clk) disable iff (reset)
    st_q.active && st_q.cnt == '0 && !start |=> !active)
    else $error("pulse outlived its count");

endmodule

// File: rtl/gcr_control_regs.sv
// gated control register group: debug, locks, clears, nvm control
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module gcr_control_regs
  import gcr_pkg::*;
#(
  parameter int ERR_CYCLES = gcr_pkg::ERR_PULSE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input gcr_pkg::gcr_bus_req_t busReq,
  output logic [gcr_pkg::DATA_W-1:0] rdData,
  input wire logic inFailsafe,
  input wire logic nvmBurnDone,
  output gcr_pkg::gcr_protect_t writeProtect,
  output logic failsafeForce,
  output logic errFlagSet,
  output logic faultOutN,
  output logic fullLogicReinit,
  output logic nvmReload,
  output logic restoreDefaults,
  output logic nvmProgramState,
  output logic nvmBurnGo,
  output logic irq
);
  import gcr_pkg::*;

  // =====================================================
  // state
  typedef struct packed {
    gcr_protect_t lock;
    logic progState;
    logic burnPend;
    logic burnDone;
    logic [EV_W-1:0] irqStat;
    logic [EV_W-1:0] irqMask;
    logic fsPulse;
    logic errPulse;
    logic reinit;
    logic reload;
    logic defaults;
    logic burnGo;
    logic [DATA_W-1:0] rdData;
  } gcr_ctl_state_t;

  localparam gcr_ctl_state_t ST_RESET = '{
    lock: gcr_protect_t'(LOCK_RESET),
    default: '0
  };

  gcr_ctl_state_t st_q;
  gcr_ctl_state_t st_d;

  logic ctrlOpen;
  logic nvmOpen;
  logic [7:0] ckeyLast;
  logic [7:0] nkeyLast;
  logic errActive;
  logic wrDbg;
  logic wrLock;
  logic wrClr;
  logic wrNvm;
  logic errStart;
  logic [EV_W-1:0] events;
  logic [DATA_W-1:0] wd;

  if (ERR_CYCLES < 1) begin : g_chk
    $error("fault pulse must last at least one cycle");
  end

  // =====================================================
  // write decode
  assign wd = busReq.wdata;
  assign wrDbg = busReq.wr && busReq.addr == OFS_DEBUG;
  assign wrLock = busReq.wr && busReq.addr == OFS_LOCK;
  assign wrClr = busReq.wr && busReq.addr == OFS_CLR;
  assign wrNvm = busReq.wr && busReq.addr == OFS_NVMCTL;

  // error pulse only in normal state
  assign errStart = wrDbg && ctrlOpen && wd[DBG_ERR_BIT] && !inFailsafe;

  // =====================================================
  // unlock sequencers
  // control key gate
  gcr_key_gate #(
    .KEY_LEN(CKEY_LEN),
    .KEY_SEQ(CKEY_SEQ)
  ) u_ctrl_key (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(st_q.reinit),
    .keyWr(busReq.wr && busReq.addr == OFS_CKEY),
    .keyByte(wd),
    .granted(ctrlOpen),
    .lastByte(ckeyLast)
  );

  gcr_key_gate #(
    .KEY_LEN(NKEY_LEN),
    .KEY_SEQ(NKEY_SEQ)
  ) u_nvm_key (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(st_q.reinit),
    .keyWr(busReq.wr && busReq.addr == OFS_NKEY),
    .keyByte(wd),
    .granted(nvmOpen),
    .lastByte(nkeyLast)
  );

  gcr_pulse_timer #(
    .CYCLES(ERR_CYCLES)
  ) u_err_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(st_q.reinit),
    .start(errStart),
    .active(errActive)
  );

  // =====================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    // self-clearing command pulses
    st_d.fsPulse = 1'b0;
    st_d.errPulse = 1'b0;
    st_d.reinit = 1'b0;
    st_d.reload = 1'b0;
    st_d.defaults = 1'b0;
    st_d.burnGo = 1'b0;
    st_d.rdData = '0;
    events = '0;

    if (wrDbg && ctrlOpen && wd[DBG_FS_BIT])
    begin
      st_d.fsPulse = 1'b1;
      events[EV_FS] = 1'b1;
    end
    if (errStart)
    begin
      st_d.errPulse = 1'b1;
      events[EV_ERR] = 1'b1;
    end

    if (wrLock && ctrlOpen)
      st_d.lock = gcr_protect_t'(wd[LOCK_W-1:0]);

    if (wrClr && ctrlOpen)
    begin
      st_d.reinit = wd[CLR_REINIT_BIT];
      st_d.reload = wd[CLR_RELOAD_BIT];
      st_d.defaults = wd[CLR_DEFAULT_BIT];
      if (wd[CLR_DEFAULT_BIT])
      begin
        st_d.lock = gcr_protect_t'(LOCK_RESET);
        st_d.progState = 1'b0;
      end
    end

    if (wrNvm && nvmOpen)
    begin
      st_d.progState = wd[NVM_MODE_BIT];
      if (wd[NVM_GO_BIT] && st_q.progState)
      begin
        st_d.burnGo = 1'b1;
        st_d.burnPend = 1'b1;
        st_d.burnDone = 1'b0;
      end
    end

    // burn completion flag, a new start keeps it low
    if (st_q.burnPend && nvmBurnDone)
    begin
      events[EV_DONE] = 1'b1;
      if (!st_d.burnGo)
      begin
        st_d.burnPend = 1'b0;
        st_d.burnDone = 1'b1;
      end
    end

    // sticky status, read clears, set wins
    if (busReq.rd && busReq.addr == OFS_IRQ_STAT)
      st_d.irqStat = events;
    else
      st_d.irqStat = st_q.irqStat | events;
    if (busReq.wr && busReq.addr == OFS_IRQ_MASK)
      st_d.irqMask = wd[EV_W-1:0];

    // read mux, data stand one cycle
    if (busReq.rd)
    begin
      case (busReq.addr)
        OFS_LOCK: st_d.rdData = DATA_W'(st_q.lock);
        OFS_CKEY: st_d.rdData = ckeyLast;
        OFS_NVMCTL: st_d.rdData = DATA_W'(st_q.progState);
        OFS_NKEY: st_d.rdData = nkeyLast;
        OFS_IRQ_STAT: st_d.rdData = DATA_W'(st_q.irqStat);
        OFS_IRQ_MASK: st_d.rdData = DATA_W'(st_q.irqMask);
        OFS_NVM_STAT: st_d.rdData = DATA_W'(st_q.burnDone);
        default: st_d.rdData = '0;
      endcase
    end

    if (st_q.reinit)
      st_d = ST_RESET;
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      st_q <= ST_RESET;
    else
      st_q <= st_d;
  end

  // =====================================================
  // outputs
  assign rdData = st_q.rdData;
  assign writeProtect = st_q.lock;
  assign failsafeForce = st_q.fsPulse;
  assign errFlagSet = st_q.errPulse;
  assign faultOutN = !errActive;
  assign fullLogicReinit = st_q.reinit;
  assign nvmReload = st_q.reload;
  assign restoreDefaults = st_q.defaults;
  assign nvmProgramState = st_q.progState;
  assign nvmBurnGo = st_q.burnGo;
  assign irq = |(st_q.irqStat & st_q.irqMask);

  // =====================================================
  // checks

  // length of the current low stretch on the fault output
  logic [15:0] lowCnt;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      lowCnt <= '0;
    else if (faultOutN || errStart)
      lowCnt <= '0;
    else
      lowCnt <= lowCnt + 16'h0001;
  end

  a_failsafe_force_pulse: assert property (
    @(posedge sys_clk) disable iff (reset)
    wrDbg && ctrlOpen && wd[DBG_FS_BIT] && !fullLogicReinit
    |=> failsafeForce ##1 (!failsafeForce
    || $past(wrDbg && ctrlOpen && wd[DBG_FS_BIT])))
    else $error("fail-safe force not a single pulse");

  a_error_pulse_start: assert property (
    @(posedge sys_clk) disable iff (reset)
    errStart && !fullLogicReinit |=> errFlagSet && !faultOutN)
    else $error("error pulse did not start");

  a_fault_low_width: assert property (
    @(posedge sys_clk) disable iff (reset)
    int'(lowCnt) <= ERR_CYCLES)
    else $error("fault output held low too long");

  a_lock_write_value: assert property (
    @(posedge sys_clk) disable iff (reset)
    wrLock && ctrlOpen && !fullLogicReinit
    |=> writeProtect == $past(wd[LOCK_W-1:0]))
    else $error("lock bits not written");

  a_lock_guard_key: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wrLock || wrClr) && !ctrlOpen && !fullLogicReinit
    |=> $stable(writeProtect) && !fullLogicReinit && !restoreDefaults)
    else $error("guarded write taken without key");

  a_soft_reinit_all: assert property (
    @(posedge sys_clk) disable iff (reset)
    wrClr && ctrlOpen && wd[CLR_REINIT_BIT] && !fullLogicReinit
    |=> fullLogicReinit ##1 (writeProtect == LOCK_RESET
    && !nvmProgramState && !fullLogicReinit))
    else $error("reinit did not restore reset state");

  a_nvm_reload_pulse: assert property (
    @(posedge sys_clk) disable iff (reset)
    wrClr && ctrlOpen && wd[CLR_RELOAD_BIT] && !fullLogicReinit
    |=> nvmReload ##1 (!nvmReload
    || $past(wrClr && ctrlOpen && wd[CLR_RELOAD_BIT])))
    else $error("reload pulse missing");

  a_default_restore: assert property (
    @(posedge sys_clk) disable iff (reset)
    wrClr && ctrlOpen && wd[CLR_DEFAULT_BIT] && !fullLogicReinit
    |=> restoreDefaults && writeProtect == LOCK_RESET)
    else $error("defaults not restored");

  a_burn_needs_mode: assert property (
    @(posedge sys_clk) disable iff (reset)
    nvmBurnGo |-> $past(nvmProgramState))
    else $error("burn started outside programming state");

  a_done_flag_pending: assert property (
    @(posedge sys_clk) disable iff (reset)
    nvmBurnGo |-> !st_q.burnDone && st_q.burnPend)
    else $error("done flag set at burn start");

  a_spare_reads_zero: assert property (
    @(posedge sys_clk) disable iff (reset)
    busReq.rd && (busReq.addr == OFS_SPARE || busReq.addr == OFS_DEBUG)
    |=> rdData == '0)
    else $error("reserved register read non-zero");

  a_debug_guard_key: assert property (
    @(posedge sys_clk) disable iff (reset)
    wrDbg && !ctrlOpen |=> !failsafeForce && !errFlagSet)
    else $error("debug write taken without key");

  a_nvm_guard_key: assert property (
    @(posedge sys_clk) disable iff (reset)
    wrNvm && !nvmOpen && !fullLogicReinit
    |=> $stable(nvmProgramState) && !nvmBurnGo)
    else $error("nvm control write taken without key");

  a_done_flag_set: assert property (
    @(posedge sys_clk) disable iff (reset)
    st_q.burnPend && nvmBurnDone && !fullLogicReinit
    && !(wrNvm && nvmOpen && wd[NVM_GO_BIT] && st_q.progState)
    |=> st_q.burnDone)
    else $error("done flag not set after burn");

endmodule

// File: dv/tb_top.sv
// self-checking bench for the gated control register group
`timescale 1ns/1ns

// =====================================================
// compare helper
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module tb_top;
  import gcr_pkg::*;

  // short error pulse so the timed phase stays cheap
  localparam int ERRC = 20;

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  gcr_bus_req_t busReq = '0;
  logic inFailsafe = 1'b0;
  logic nvmBurnDone = 1'b0;
  logic [DATA_W-1:0] rdData;
  gcr_protect_t writeProtect;
  logic failsafeForce;
  logic errFlagSet;
  logic faultOutN;
  logic fullLogicReinit;
  logic nvmReload;
  logic restoreDefaults;
  logic nvmProgramState;
  logic nvmBurnGo;
  logic irq;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] d;
  logic [7:0] expLock;
  logic [7:0] cKey [4] = '{8'h43, 8'h4f, 8'h44, 8'h45};
  logic [7:0] nKey [6] = '{8'h00, 8'h04, 8'h02, 8'h09, 8'h02, 8'h09};

  // =====================================================
  // device under test
  gcr_control_regs #(.ERR_CYCLES(ERRC)) u_dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .busReq(busReq),
    .rdData(rdData),
    .inFailsafe(inFailsafe),
    .nvmBurnDone(nvmBurnDone),
    .writeProtect(writeProtect),
    .failsafeForce(failsafeForce),
    .errFlagSet(errFlagSet),
    .faultOutN(faultOutN),
    .fullLogicReinit(fullLogicReinit),
    .nvmReload(nvmReload),
    .restoreDefaults(restoreDefaults),
    .nvmProgramState(nvmProgramState),
    .nvmBurnGo(nvmBurnGo),
    .irq(irq)
  );

  // clock of 10 ns
  always #5 sys_clk = ~sys_clk;

  // hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      test_done();
    end
  end

  // =====================================================
  // bus and closing tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
    `CHK(rdData, e);
  endtask

  task automatic ckey();
    foreach (cKey[i]) wr(OFS_CKEY, cKey[i]);
  endtask

  task automatic nkey();
    foreach (nKey[i]) wr(OFS_NKEY, nKey[i]);
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // =====================================================
  // main sequence
  initial
  begin
    void'($urandom(43));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    `CHK(writeProtect, 3'b011);
    `CHK(faultOutN, 1'b1);
    rdChk(OFS_LOCK, 8'h03);
    rdChk(OFS_NVMCTL, 8'h00);
    rdChk(OFS_SPARE, 8'h00);
    rdChk(8'h7f, 8'h00);
    // guarded write refused before the key
    wr(OFS_LOCK, 8'h04);
    `CHK(writeProtect, 3'b011);
    wr(OFS_DEBUG, 8'h03);
    `CHK(failsafeForce, 1'b0);
    `CHK(errFlagSet, 1'b0);
    wr(OFS_CLR, 8'h07);
    `CHK(fullLogicReinit, 1'b0);
    `CHK(nvmReload, 1'b0);
    ckey();
    // random lock values, upper bits dropped, spare stays zero
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      expLock = d & 8'h07;
      wr(OFS_LOCK, d);
      `CHK(writeProtect, expLock[2:0]);
      rdChk(OFS_LOCK, expLock);
      wr(OFS_SPARE, d);
      rdChk(OFS_SPARE, 8'h00);
    end
    rdChk(OFS_CKEY, 8'h45);
    // wrong byte drops the grant
    wr(OFS_CKEY, 8'h43);
    wr(OFS_CKEY, 8'h00);
    wr(OFS_LOCK, ~expLock);
    `CHK(writeProtect, expLock[2:0]);
    ckey();
    // forced fail-safe pulse
    wr(OFS_DEBUG, 8'h02);
    `CHK(failsafeForce, 1'b1);
    `CHK(errFlagSet, 1'b0);
    @(posedge sys_clk);
    #1;
    `CHK(failsafeForce, 1'b0);
    rdChk(OFS_DEBUG, 8'h00);
    // error pulse and timed fault low phase
    wr(OFS_DEBUG, 8'h01);
    `CHK(errFlagSet, 1'b1);
    n = 0;
    while (faultOutN === 1'b0 && n < 100)
    begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    `CHK(n, ERRC);
    // no error pulse while in fail-safe
    inFailsafe <= 1'b1;
    wr(OFS_DEBUG, 8'h01);
    `CHK(errFlagSet, 1'b0);
    `CHK(faultOutN, 1'b1);
    inFailsafe <= 1'b0;
    // interrupt masked, unmasked, cleared by read
    `CHK(irq, 1'b0);
    wr(OFS_IRQ_MASK, 8'h02);
    @(posedge sys_clk);
    #1;
    `CHK(irq, 1'b1);
    rdChk(OFS_IRQ_STAT, 8'h06);
    @(posedge sys_clk);
    #1;
    `CHK(irq, 1'b0);
    rdChk(OFS_IRQ_STAT, 8'h00);
    // nvm control gated by its own key
    wr(OFS_NVMCTL, 8'h01);
    `CHK(nvmProgramState, 1'b0);
    nkey();
    wr(OFS_NVMCTL, 8'h03);
    `CHK(nvmProgramState, 1'b1);
    `CHK(nvmBurnGo, 1'b0);
    rdChk(OFS_NVMCTL, 8'h01);
    wr(OFS_NVMCTL, 8'h03);
    `CHK(nvmBurnGo, 1'b1);
    rdChk(OFS_NVM_STAT, 8'h00);
    @(posedge sys_clk);
    nvmBurnDone <= 1'b1;
    @(posedge sys_clk);
    nvmBurnDone <= 1'b0;
    rdChk(OFS_NVM_STAT, 8'h01);
    rdChk(OFS_IRQ_STAT, 8'h01);
    // reload and restore commands
    wr(OFS_CLR, 8'h02);
    `CHK(nvmReload, 1'b1);
    `CHK(restoreDefaults, 1'b0);
    wr(OFS_LOCK, 8'h04);
    wr(OFS_CLR, 8'h01);
    `CHK(restoreDefaults, 1'b1);
    `CHK(writeProtect, 3'b011);
    `CHK(nvmProgramState, 1'b0);
    rdChk(OFS_CLR, 8'h00);
    // full reinit drops lock, mask and key grant
    wr(OFS_LOCK, 8'h04);
    `CHK(writeProtect, 3'b100);
    wr(OFS_CLR, 8'h04);
    `CHK(fullLogicReinit, 1'b1);
    @(posedge sys_clk);
    #1;
    `CHK(writeProtect, 3'b011);
    wr(OFS_LOCK, 8'h04);
    `CHK(writeProtect, 3'b011);
    rdChk(OFS_IRQ_MASK, 8'h00);
    test_done();
  end
endmodule
